// file: core/sfr_bank_defines.svh
/*
  Offsets, field positions and reset values of the bank 0 special function
  register map. Included by the register bank design file by bare name.
*/
`ifndef SFR_BANK_DEFINES_SVH
`define SFR_BANK_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define OFS_INDIRECT_PORT 7'h00
`define OFS_TIMER_COUNT 7'h01
`define OFS_PC_LOW_BYTE 7'h02
`define OFS_CORE_STATUS 7'h03
`define OFS_INDIRECT_POINTER 7'h04
`define OFS_PORT_PINS 7'h05
`define OFS_PC_HIGH_LATCH 7'h0A
`define OFS_INTERRUPT_CONTROL 7'h0B
`define OFS_PERIPHERAL_IRQ 7'h0C
`define OFS_CONVERSION_RESULT 7'h1E
`define OFS_CONVERTER_CONTROL 7'h1F

// core status fields
`define BIT_INDIRECT_BANK 7
`define BIT_BANK_HIGH 6
`define BIT_BANK_LOW 5
`define BIT_TIME_OUT 4
`define BIT_POWER_DOWN 3

// interrupt control and peripheral flags
`define BIT_TIMER_FLAG 2
`define BIT_EDGE_FLAG 1
`define BIT_CHANGE_FLAG 0
`define BIT_CONV_FLAG 6
`define MASK_PERIPHERAL_IRQ 8'h40

// converter control fields; reserved bits 5 and 1 are not stored
`define BIT_CONV_GO 2
`define MASK_CONVERTER_CONTROL 8'hDD

// reset values
`define RST_ZERO_BYTE 8'h00
`define RST_STATUS_POR 8'h18
`define RST_PORT_SERIAL_POR 2'h3
`define RST_PC_HIGH_LATCH 5'h00

`endif

// file: core/sfr_bank_pkg.sv
/*
  Types shared by the register bank and its helpers.
  Assumes the defines header is on the include path.
*/
package sfr_bank_pkg;

  // classic wishbone request as the master drives it
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  // data memory access made through the indirect port
  typedef struct packed {
    logic req;
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } mem_req_type;

  // upper program counter transfer
  typedef struct packed {
    logic load;
    logic [12:0] target;
  } pc_load_type;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_INDIRECT = 4'h1,
    SEL_TIMER = 4'h2,
    SEL_PC_LOW = 4'h3,
    SEL_STATUS = 4'h4,
    SEL_POINTER = 4'h5,
    SEL_PORT = 4'h6,
    SEL_PC_HIGH = 4'h7,
    SEL_INT_CTRL = 4'h8,
    SEL_PERIPH_IRQ = 4'h9,
    SEL_CONV_RESULT = 4'hA,
    SEL_CONV_CTRL = 4'hB
  } reg_sel_type;

endpackage

// file: core/sfr_sync.sv
/*
  Two flip-flop synchroniser for pin levels.
  Assumes inputs are asynchronous to core_clk; only the second stage is read.
*/
`timescale 1ns/1ps
`default_nettype none

module sfr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      first_stage <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end

endmodule // sfr_sync

`default_nettype wire

// file: core/sfr_wb_port.sv
/*
  Classic wishbone slave handshake: one commit pulse per request, ack one
  cycle later. Assumes the master holds its request until it sees ack.
*/
`timescale 1ns/1ps
`default_nettype none

module sfr_wb_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bus strobes
  input wire logic cyc,
  input wire logic stb,
  // low while the access is waiting on data memory
  input wire logic ready,
  // handshake
  output logic commit,
  output logic ack
);

  // ack high blocks a second commit while the master still holds the request
  assign commit = cyc && stb && !ack && ready;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ack <= 1'b0;
    else
      ack <= commit;
  end

endmodule // sfr_wb_port

`default_nettype wire

// file: core/sfr_bank0.sv
/*
  Bank 0 special function registers behind a classic wishbone slave.
  Assumes the data memory answers mem_ack on core_clk, the peripherals give
  one-cycle event pulses on core_clk, and srst is the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfr_bank_defines.svh"

// Behaviour
// - mirrored core registers decode the same whichever bank is selected
// - upper program counter bits come only from the writable high latch
// - unimplemented bank 0 locations read zero
// - without serial memory, port bits seven and six read zero
// - every reset clears pc low, converter control, high latch
// - status is 0001 1xxx on power-on, 000q quuu otherwise
// - port and interrupt control reset values; other resets keep listed bits
// - indirect port has no storage; accesses reach memory at the pointer
// - status bit five selects bank one when set
module sfr_bank0 #(
  parameter bit HAS_SERIAL_MEM = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register bus
  input wire sfr_bank_pkg::wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // data memory behind the indirect port
  output sfr_bank_pkg::mem_req_type mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // reset causes
  input wire logic master_clear_pin_n,
  input wire logic watchdog_reset,
  input wire logic core_asleep,
  // peripheral events
  input wire logic timer_tick,
  input wire logic ext_edge,
  input wire logic pin_change,
  input wire logic conv_done,
  input wire logic [7:0] conv_value,
  // port pins
  input wire logic [7:0] port_pins_in,
  output logic [7:0] port_latch,
  // to the core and peripherals
  output sfr_bank_pkg::pc_load_type pc_load,
  output logic bank_select_low,
  output logic [7:0] interrupt_control_out,
  output logic [7:0] converter_control_out
);

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] timer_count;
  logic [7:0] pc_low_byte;
  logic [7:0] core_status_flags;
  logic [7:0] indirect_pointer;
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] conversion_result;
  logic [7:0] converter_control;
  logic [4:0] pc_high_latch;
  logic [7:0] port_sync;
  logic master_clear_pin_sync_n;
  logic other_reset;
  logic commit;
  logic ready;
  logic wr;
  logic [6:0] index;
  logic in_range;
  logic [7:0] wdata;
  logic pointer_self;
  logic [7:0] port_read;
  logic [7:0] next_read;
  logic [7:0] next_status;
  logic [7:0] port_mask;
  sfr_bank_pkg::reg_sel_type sel;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // bank 1 locations other than the mirrors belong to another block
  function automatic sfr_bank_pkg::reg_sel_type decode(
    input logic [6:0] idx,
    input logic bank_one
  );
    sfr_bank_pkg::reg_sel_type s;
    s = sfr_bank_pkg::SEL_NONE;
    unique case (idx)
      `OFS_INDIRECT_PORT: s = sfr_bank_pkg::SEL_INDIRECT;
      `OFS_PC_LOW_BYTE: s = sfr_bank_pkg::SEL_PC_LOW;
      `OFS_CORE_STATUS: s = sfr_bank_pkg::SEL_STATUS;
      `OFS_INDIRECT_POINTER: s = sfr_bank_pkg::SEL_POINTER;
      `OFS_PC_HIGH_LATCH: s = sfr_bank_pkg::SEL_PC_HIGH;
      `OFS_INTERRUPT_CONTROL: s = sfr_bank_pkg::SEL_INT_CTRL;
      `OFS_TIMER_COUNT:
        s = bank_one ? sfr_bank_pkg::SEL_NONE : sfr_bank_pkg::SEL_TIMER;
      `OFS_PORT_PINS:
        s = bank_one ? sfr_bank_pkg::SEL_NONE : sfr_bank_pkg::SEL_PORT;
      `OFS_PERIPHERAL_IRQ:
        s = bank_one ? sfr_bank_pkg::SEL_NONE : sfr_bank_pkg::SEL_PERIPH_IRQ;
      `OFS_CONVERSION_RESULT:
        s = bank_one ? sfr_bank_pkg::SEL_NONE : sfr_bank_pkg::SEL_CONV_RESULT;
      `OFS_CONVERTER_CONTROL:
        s = bank_one ? sfr_bank_pkg::SEL_NONE : sfr_bank_pkg::SEL_CONV_CTRL;
      default: s = sfr_bank_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  assign index = wb_req.adr[8:2];
  // upper address bits set is an unmapped access
  assign in_range = (wb_req.adr[31:9] == 23'h000000);
  assign bank_select_low = core_status_flags[`BIT_BANK_LOW];
  assign sel = in_range ? decode(index, bank_select_low)
                        : sfr_bank_pkg::SEL_NONE;
  assign wdata = wb_req.dat[7:0];
  // write only when the low byte lane is enabled
  assign wr = commit && wb_req.we && wb_req.sel[0];
  assign pointer_self = (indirect_pointer == `RST_ZERO_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake and indirect memory access

  // pointing the indirect port at itself touches no memory
  assign ready = !(sel == sfr_bank_pkg::SEL_INDIRECT) || pointer_self
                 || mem_ack;

  sfr_wb_port u_wb_port (
    .core_clk(core_clk),
    .srst(srst),
    .cyc(wb_req.cyc),
    .stb(wb_req.stb),
    .ready(ready),
    .commit(commit),
    .ack(wb_ack_o)
  );

  always_comb
  begin
    mem_req.req = wb_req.cyc && wb_req.stb && !wb_ack_o
                  && (sel == sfr_bank_pkg::SEL_INDIRECT) && !pointer_self;
    mem_req.we = wb_req.we && wb_req.sel[0];
    mem_req.addr = {core_status_flags[`BIT_INDIRECT_BANK], indirect_pointer};
    mem_req.wdata = wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset causes and pins

  sfr_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) u_master_clear_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(master_clear_pin_n),
    .sync_out(master_clear_pin_sync_n)
  );

  sfr_sync #(
    .WIDTH(8),
    .RESET_VALUE(8'h00)
  ) u_port_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(port_pins_in),
    .sync_out(port_sync)
  );

  // held while the pin stays low
  assign other_reset = !master_clear_pin_sync_n || watchdog_reset;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  assign port_mask = HAS_SERIAL_MEM ? 8'hFF : 8'h3F;
  assign port_read = port_sync & port_mask;

  always_comb
  begin
    next_read = 8'h00;
    unique case (sel)
      sfr_bank_pkg::SEL_INDIRECT: next_read = pointer_self ? 8'h00 : mem_rdata;
      sfr_bank_pkg::SEL_TIMER: next_read = timer_count;
      sfr_bank_pkg::SEL_PC_LOW: next_read = pc_low_byte;
      sfr_bank_pkg::SEL_STATUS: next_read = core_status_flags;
      sfr_bank_pkg::SEL_POINTER: next_read = indirect_pointer;
      sfr_bank_pkg::SEL_PORT: next_read = port_read;
      sfr_bank_pkg::SEL_PC_HIGH: next_read = {3'h0, pc_high_latch};
      sfr_bank_pkg::SEL_INT_CTRL: next_read = interrupt_control;
      sfr_bank_pkg::SEL_PERIPH_IRQ: next_read = peripheral_irq_flags;
      sfr_bank_pkg::SEL_CONV_RESULT: next_read = conversion_result;
      sfr_bank_pkg::SEL_CONV_CTRL: next_read = converter_control;
      sfr_bank_pkg::SEL_NONE: next_read = 8'h00;
      default: next_read = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      wb_dat_o <= 32'h00000000;
    else if (commit && !wb_req.we)
      wb_dat_o <= {24'h000000, next_read};
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter

  always_ff @(posedge core_clk)
  begin
    if (srst || other_reset)
    begin
      pc_low_byte <= `RST_ZERO_BYTE;
      pc_high_latch <= `RST_PC_HIGH_LATCH;
    end
    else if (wr && sel == sfr_bank_pkg::SEL_PC_LOW)
      pc_low_byte <= wdata;
    else if (wr && sel == sfr_bank_pkg::SEL_PC_HIGH)
      pc_high_latch <= wdata[4:0];
  end

  // the upper counter bits are only ever loaded from the latch
  always_ff @(posedge core_clk)
  begin
    if (srst || other_reset)
      pc_load <= '0;
    else
    begin
      pc_load.load <= wr && sel == sfr_bank_pkg::SEL_PC_LOW;
      pc_load.target <= {pc_high_latch, wdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core status

  // power-down and time-out flags are read only
  assign next_status = {wdata[7:5], core_status_flags[4:3], wdata[2:0]};

  always_ff @(posedge core_clk)
  begin
    if (srst)
      core_status_flags <= `RST_STATUS_POR;
    else if (other_reset)
    begin
      core_status_flags[7:5] <= 3'h0;
      core_status_flags[`BIT_TIME_OUT] <= !watchdog_reset;
      core_status_flags[`BIT_POWER_DOWN] <= !core_asleep;
    end
    else if (wr && sel == sfr_bank_pkg::SEL_STATUS)
      core_status_flags <= next_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer, timer, port latch

  // pointer and timer keep their contents over non power-up resets
  always_ff @(posedge core_clk)
  begin
    if (srst)
      indirect_pointer <= `RST_ZERO_BYTE;
    else if (wr && sel == sfr_bank_pkg::SEL_POINTER && !other_reset)
      indirect_pointer <= wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      timer_count <= `RST_ZERO_BYTE;
    else if (other_reset)
      timer_count <= timer_count;
    else if (wr && sel == sfr_bank_pkg::SEL_TIMER)
      timer_count <= wdata;
    else if (timer_tick)
      timer_count <= timer_count + 8'h01;
  end

  // bits 7:6 exist only with serial memory; every reset sets them again
  always_ff @(posedge core_clk)
  begin
    if (srst)
      port_latch <= {HAS_SERIAL_MEM ? `RST_PORT_SERIAL_POR : 2'h0, 6'h00};
    else if (other_reset)
      port_latch[7:6] <= HAS_SERIAL_MEM ? `RST_PORT_SERIAL_POR : 2'h0;
    else if (wr && sel == sfr_bank_pkg::SEL_PORT)
      port_latch <= {HAS_SERIAL_MEM ? wdata[7:6] : 2'h0, wdata[5:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt control and peripheral flags

  // hardware events win over a clearing write in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
      interrupt_control <= `RST_ZERO_BYTE;
    else if (other_reset)
      interrupt_control[7:1] <= 7'h00;
    else
    begin
      if (wr && sel == sfr_bank_pkg::SEL_INT_CTRL)
        interrupt_control <= wdata;
      if (timer_tick && timer_count == 8'hFF
          && !(wr && sel == sfr_bank_pkg::SEL_TIMER))
        interrupt_control[`BIT_TIMER_FLAG] <= 1'b1;
      if (ext_edge)
        interrupt_control[`BIT_EDGE_FLAG] <= 1'b1;
      if (pin_change)
        interrupt_control[`BIT_CHANGE_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || other_reset)
      peripheral_irq_flags <= `RST_ZERO_BYTE;
    else if (conv_done)
      peripheral_irq_flags[`BIT_CONV_FLAG] <= 1'b1;
    else if (wr && sel == sfr_bank_pkg::SEL_PERIPH_IRQ)
      peripheral_irq_flags <= wdata & `MASK_PERIPHERAL_IRQ;
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter

  always_ff @(posedge core_clk)
  begin
    if (srst)
      conversion_result <= `RST_ZERO_BYTE;
    else if (other_reset)
      conversion_result <= conversion_result;
    else if (conv_done)
      conversion_result <= conv_value;
    else if (wr && sel == sfr_bank_pkg::SEL_CONV_RESULT)
      conversion_result <= wdata;
  end

  // finish clears the go bit; a finish overrides a go bit written in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst || other_reset)
      converter_control <= `RST_ZERO_BYTE;
    else
    begin
      if (wr && sel == sfr_bank_pkg::SEL_CONV_CTRL)
        converter_control <= wdata & `MASK_CONVERTER_CONTROL;
      if (conv_done)
        converter_control[`BIT_CONV_GO] <= 1'b0;
    end
  end

  assign interrupt_control_out = interrupt_control;
  assign converter_control_out = converter_control;

endmodule // sfr_bank0

`default_nettype wire

// file: dv/sfr_mem_model.sv
/* data memory model behind the indirect port
   assumes requests stay up until mem_ack is seen */
`timescale 1ns/1ps
`default_nettype none
module sfr_mem_model (
  // clock
  input wire logic core_clk,
  // request, answer delay and answer
  input wire sfr_bank_pkg::mem_req_type mem_req,
  input wire logic [1:0] delay,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [512];
  logic [7:0] last;
  logic [1:0] cnt;
  initial
  begin
    mem_ack = 1'b0;
    cnt = 2'h0;
    last = 8'h00;
  end
  // read data is only valid with ack; otherwise show a changed value
  always @(posedge core_clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~last;
    if (mem_req.req && !mem_ack)
    begin
      cnt <= cnt + 2'h1;
      if (cnt == delay)
      begin
        cnt <= 2'h0;
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_req.addr];
        last <= mem[mem_req.addr];
        if (mem_req.we)
          mem[mem_req.addr] <= mem_req.wdata;
      end
    end
  end
endmodule // sfr_mem_model
`default_nettype wire

// file: dv/sfr_bank0_chk.sv
/* assertions on the bank 0 register ports
   assumes one clock, srst as the reset */
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0_chk #(
  parameter bit HAS_SERIAL_MEM = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // watched ports
  input wire sfr_bank_pkg::wb_req_type wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire sfr_bank_pkg::mem_req_type mem_req,
  input wire logic mem_ack,
  input wire logic watchdog_reset,
  input wire logic ext_edge,
  input wire logic pin_change,
  input wire logic [7:0] port_latch,
  input wire sfr_bank_pkg::pc_load_type pc_load,
  input wire logic bank_select_low,
  input wire logic [7:0] interrupt_control_out,
  input wire logic [7:0] converter_control_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [6:0] idx;
  logic rd_ack, pcw, wst, b5;
  assign idx = wb_req.adr[8:2];
  assign rd_ack = wb_ack_o && !wb_req.we;
  assign pcw = wb_ack_o && wb_req.we && wb_req.sel[0] && wb_req.adr == 32'h8;
  assign wst = wb_ack_o && wb_req.we && wb_req.sel[0] && wb_req.adr == 32'hC;
  always_ff @(posedge core_clk)
    if (wst)
      b5 <= wb_req.dat[5];
  ////////////////////////////////////////////////////////////////////
  a_unmapped_read_zero: assert property (rd_ack && (wb_req.adr[31:9] != 0 ||
    idx inside {[6:9], [13:29]}) |-> wb_dat_o == 32'h0) else $error("unmapped read not 0");
  a_port_top_zero: assert property (rd_ack && wb_req.adr == 32'h14 && !HAS_SERIAL_MEM
    |-> wb_dat_o[7:6] == 2'h0) else $error("port top bits not 0");
  a_latch_top_empty: assert property (!HAS_SERIAL_MEM |-> port_latch[7:6] == 2'h0)
    else $error("port top bits stored");
  a_pc_load_follows: assert property (pcw |-> ##[0:1] pc_load.load)
    else $error("no pc load after pc low write");
  a_pc_load_single: assert property (pc_load.load |=> !pc_load.load)
    else $error("pc load longer than a cycle");
  a_bank_follows: assert property (wst |=> bank_select_low == b5)
    else $error("bank select not status bit 5");
  a_por_values: assert property ($fell(srst) |-> converter_control_out == 8'h0 &&
    interrupt_control_out == 8'h0 && port_latch == {{2{HAS_SERIAL_MEM}}, 6'h0})
    else $error("power-on values wrong");
  a_wdt_clears: assert property (watchdog_reset && !ext_edge |=>
    converter_control_out == 8'h0 && interrupt_control_out[7:1] == 7'h0)
    else $error("watchdog did not clear");
  a_wdt_keeps: assert property (watchdog_reset && !pin_change |=>
    $stable(interrupt_control_out[0]) && $stable(port_latch)) else $error("watchdog lost bits");
  a_indirect_answer: assert property (mem_ack && mem_req.req |=> wb_ack_o)
    else $error("no ack after memory answer");
endmodule // sfr_bank0_chk
bind sfr_bank0 sfr_bank0_chk #(.HAS_SERIAL_MEM(HAS_SERIAL_MEM)) chk (.core_clk(core_clk),
  .srst(srst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mem_req(mem_req), .mem_ack(mem_ack), .watchdog_reset(watchdog_reset),
  .ext_edge(ext_edge), .pin_change(pin_change), .port_latch(port_latch),
  .pc_load(pc_load), .bank_select_low(bank_select_low),
  .interrupt_control_out(interrupt_control_out),
  .converter_control_out(converter_control_out));
`default_nettype wire

// file: dv/core_sfr_bank0_map_test.sv
/* self-checking bench for the bank 0 register map
   assumes the memory model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
module core_sfr_bank0_map_test;
  logic core_clk, srst, wb_ack_o, mem_ack, master_clear_pin_n, watchdog_reset, core_asleep;
  logic timer_tick, ext_edge, pin_change, conv_done, bank_select_low;
  logic [7:0] conv_value, port_pins_in, port_latch, mem_rdata, ico, cco, cv;
  logic [31:0] wb_dat_o, seed;
  logic [1:0] delay;
  sfr_bank_pkg::wb_req_type wb_req;
  sfr_bank_pkg::mem_req_type mem_req;
  sfr_bank_pkg::pc_load_type pc_load;
  int fails, total_checks;
  logic [7:0] q[$];
  logic [12:0] pq[$];
  logic [6:0] ix [6] = '{7'h01, 7'h04, 7'h0A, 7'h0B, 7'h0C, 7'h1F};
  logic [7:0] mk [6] = '{8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h40, 8'hDD};
  sfr_bank0 dut (.core_clk(core_clk), .srst(srst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .master_clear_pin_n(master_clear_pin_n), .watchdog_reset(watchdog_reset),
    .core_asleep(core_asleep), .timer_tick(timer_tick), .ext_edge(ext_edge),
    .pin_change(pin_change), .conv_done(conv_done), .conv_value(conv_value),
    .port_pins_in(port_pins_in), .port_latch(port_latch), .pc_load(pc_load),
    .bank_select_low(bank_select_low), .interrupt_control_out(ico),
    .converter_control_out(cco));
  sfr_mem_model mem (.core_clk(core_clk), .mem_req(mem_req), .delay(delay),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: read %h want %h", $time, g, e);
    end
  endtask
  task automatic chkpc(input logic [12:0] e, input logic [12:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: pc %h want %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    if (q.size() != 0 || pq.size() != 0)
      fails++;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one classic cycle; the master holds everything until ack is sampled
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
    wb_req <= '{1'b1, 1'b1, w, 4'hF, a, {24'h0, d}};
    // no local limit: only the watchdog ends a wait for ack
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    wb_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    q.push_back(e);
    wb(1'b0, {23'h0, i, 2'h0}, 8'h00);
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    wb(1'b1, {23'h0, i, 2'h0}, d);
  endtask
  task automatic step;
    @(posedge core_clk);
    {watchdog_reset, timer_tick, ext_edge, pin_change, conv_done} <= 5'h0;
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (wb_ack_o === 1'b1 && wb_req.we === 1'b0)
      chk8(q.pop_front(), wb_dat_o[7:0]);
    if (pc_load.load === 1'b1)
      chkpc(pq.pop_front(), pc_load.target);
  end
  initial
  begin
    repeat (8000) @(posedge core_clk);
    fails++;
    $display("Error %0t: run too long", $time);
    stop_test();
  end
  initial
  begin
    wb_req = '0;
    srst = 1'b1;
    {master_clear_pin_n, watchdog_reset, core_asleep, timer_tick} = 4'h8;
    {ext_edge, pin_change, conv_done, delay} = 5'h0;
    seed = 32'h4E8F876E;
    port_pins_in = seed[7:0];
    conv_value = 8'h00;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(7'h03, 8'h18);
    rd(7'h02, 8'h00);
    rd(7'h0A, 8'h00);
    rd(7'h1F, 8'h00);
    rd(7'h0B, 8'h00);
    rd(7'h00, 8'h00);
    rd(7'h05, seed[7:0] & 8'h3F);
    $display("power-on test done");
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      wr(ix[k], seed[7:0]);
      rd(ix[k], seed[7:0] & mk[k]);
    end
    wr(7'h03, {3'h0, seed[4:0]});
    rd(7'h03, {5'h03, seed[2:0]});
    for (int i = 6; i < 30; i++)
      if (i < 10 || i > 12)
      begin
        wr(i[6:0], 8'hFF);
        rd(i[6:0], 8'h00);
      end
    q.push_back(8'h00);
    wb(1'b0, 32'h208, 8'h00);
    $display("map test done");
    wr(7'h04, 8'h35);
    wr(7'h0A, 8'h13);
    wr(7'h03, 8'h20);
    rd(7'h04, 8'h35);
    rd(7'h0A, 8'h13);
    rd(7'h03, 8'h38);
    rd(7'h01, 8'h00);
    rd(7'h1F, 8'h00);
    wr(7'h03, 8'h00);
    $display("bank test done");
    delay <= 2'h3;
    wr(7'h00, 8'hA5);
    rd(7'h00, 8'hA5);
    delay <= 2'h0;
    wr(7'h04, 8'h36);
    wr(7'h00, 8'h5A);
    rd(7'h00, 8'h5A);
    wr(7'h04, 8'h35);
    rd(7'h00, 8'hA5);
    $display("indirect test done");
    pq.push_back(13'h135A);
    wr(7'h02, 8'h5A);
    rd(7'h02, 8'h5A);
    $display("pc test done");
    seed = lfsr(seed);
    cv = seed[7:0];
    conv_value <= cv;
    conv_done <= 1'b1;
    pin_change <= 1'b1;
    step();
    rd(7'h0C, 8'h40);
    wr(7'h1F, 8'h41);
    wr(7'h0B, 8'h81);
    wr(7'h01, 8'h9C);
    wr(7'h03, 8'h05);
    core_asleep <= 1'b1;
    watchdog_reset <= 1'b1;
    step();
    rd(7'h02, 8'h00);
    rd(7'h0A, 8'h00);
    rd(7'h1F, 8'h00);
    rd(7'h03, 8'h05);
    rd(7'h0B, 8'h01);
    rd(7'h04, 8'h35);
    rd(7'h01, 8'h9C);
    rd(7'h1E, cv);
    $display("watchdog test done");
    wr(7'h1F, 8'h41);
    wr(7'h03, 8'h02);
    wr(7'h05, 8'hFF);
    core_asleep <= 1'b0;
    master_clear_pin_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    master_clear_pin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk8(8'h3F, port_latch);
    rd(7'h1F, 8'h00);
    rd(7'h03, 8'h1A);
    timer_tick <= 1'b1;
    ext_edge <= 1'b1;
    step();
    rd(7'h01, 8'h9D);
    rd(7'h0B, 8'h03);
    wr(7'h01, 8'hFF);
    timer_tick <= 1'b1;
    step();
    rd(7'h01, 8'h00);
    rd(7'h0B, 8'h07);
    seed = lfsr(seed);
    port_pins_in <= seed[7:0];
    repeat (4) @(posedge core_clk);
    rd(7'h05, seed[7:0] & 8'h3F);
    $display("master clear test done");
    repeat (3) @(posedge core_clk);
    stop_test();
  end
endmodule // core_sfr_bank0_map_test
`default_nettype wire
